// file: rtl/hsfc_top.v
// Host serial port of the radio controller, data set side: 8N1 UART,
// handshake lines, software flow characters, echo and soft reset.
// Assumes ref_clk at 20 MHz and a plain register port from local logic.
//
// Overview of operation
// - Restart character to host is programmable, reset value 0x11.
// - Halt character to host is programmable, reset value 0x13.
// - Characters to the host start only while its request-to-send grants it.
// - Clear-to-send drops while incoming host data cannot be taken.
// - Data-set-ready stays asserted while the unit runs.
// - Carrier-detect follows the connection of the selected stream.
// - Data-terminal-ready is ignored entirely.
// - Characters are eight data bits, no parity, one stop bit.
// - Bit rates 300 to 19200 baud in doubling steps.
// - Received host characters are echoed back by default.
// - Polled mode acts only with extended host framing; off at reset.
// - A low on the external reset input, when enabled, soft resets.
// - Without software flow, flow characters are neither sent nor obeyed.
// - With software flow, host stop halts echo and data output and host start resumes.
`timescale 1ns/1ps
`include "hsfc_regs.vh"
module hsfc_top
#(
   parameter CLK_HZ = `HSFC_CLK_HZ
)
(
   input  wire       ref_clk,
   input  wire       rst_n,
   input  wire [2:0] bus_addr,
   input  wire [7:0] bus_wdata,
   input  wire       bus_wr,
   input  wire       bus_rd,
   output reg  [7:0] bus_rdata,
   input  wire       host_txd,
   output reg        host_rxd,
   input  wire       host_rts,
   output reg        host_cts,
   output reg        host_dsr,
   output reg        host_dcd,
   input  wire       host_dtr,
   input  wire       external_reset_input_n,
   input  wire       stream_connected,
   output reg        tx_space,
   output reg        soft_reset,
   output reg        extended_host_framing,
   output reg        polled_active
);
   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   localparam [1:0] S_IDLE  = 2'h0;
   localparam [1:0] S_START = 2'h1;
   localparam [1:0] S_DATA  = 2'h2;
   localparam [1:0] S_STOP  = 2'h3;

   reg  [7:0]  ctrl_reg;
   reg  [7:0]  xon_reg;
   reg  [7:0]  xoff_reg;
   reg  [7:0]  start_reg;
   reg  [7:0]  stop_reg;
   reg  [12:0] bcnt_reg;
   reg         tick_reg;
   reg  [1:0]  tx_state_reg;
   reg  [7:0]  tx_sh_reg;
   reg  [2:0]  tx_bit_reg;
   reg  [3:0]  tx_ph_reg;
   reg  [1:0]  rx_state_reg;
   reg  [7:0]  rx_sh_reg;
   reg  [2:0]  rx_bit_reg;
   reg  [3:0]  rx_ph_reg;
   reg         rx_done_reg;
   reg  [7:0]  rx_hold_reg;
   reg         rx_valid_reg;
   reg  [7:0]  echo_reg;
   reg         echo_pend_reg;
   reg         paused_reg;
   reg         host_held_reg;
   reg         ext_prev_reg;
   wire [2:0]  pins_s;
   wire        rxd_s;
   wire        rts_s;
   wire        ext_s;
   wire        buf_in_ready;
   wire        buf_out_valid;
   wire        buf_out_ready;
   wire [7:0]  buf_out_data;
   wire        buf_push;
   wire        sw_en;
   wire        need_xoff;
   wire        need_xon;
   wire        go_flow;
   wire        go_echo;
   wire        go_data;
   wire        is_stop;
   wire        is_start;
   wire        rx_keep;
   wire        rx_read;
   wire [12:0] bdiv;

   // Rounded divisor for the 16x tick at 300 << sel baud, sel above 6 taken as 6
   function [12:0] baud_div;
      input [2:0] sel;
      integer     b;
      integer     q;
      begin
         b        = `HSFC_BAUD_MIN << ((sel > 3'h6) ? 3'h6 : sel);
         q        = (CLK_HZ + (`HSFC_OVS / 2) * b) / (`HSFC_OVS * b);
         baud_div = q[12:0];
      end
   endfunction

   // ----------------------------------------------------------------
   // Pin synchronisers and buffer
   // ----------------------------------------------------------------
   hsfc_sync3 #(.W(3), .RST_VAL(3'h7)) u_sync
   (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .pin_in  ({external_reset_input_n, host_rts, host_txd}),
      .pin_out (pins_s)
   );
   assign rxd_s = pins_s[0];
   assign rts_s = pins_s[1];
   assign ext_s = pins_s[2];

   // Transmit bytes wait here
   assign buf_push = bus_wr && (bus_addr == `HSFC_A_TXDATA);
   hsfc_buf2 u_buf
   (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .clr       (soft_reset),
      .in_valid  (buf_push),
      .in_ready  (buf_in_ready),
      .in_data   (bus_wdata),
      .out_valid (buf_out_valid),
      .out_ready (buf_out_ready),
      .out_data  (buf_out_data)
   );

   // ----------------------------------------------------------------
   // Flow decisions
   // ----------------------------------------------------------------
   // Software flow needs every character nonzero
   assign sw_en = ctrl_reg[`HSFC_F_XFLOW] && (xon_reg != 8'h00) && (xoff_reg != 8'h00)
                  && (start_reg != 8'h00) && (stop_reg != 8'h00);
   assign need_xoff = sw_en && rx_valid_reg && !host_held_reg;
   assign need_xon  = sw_en && !rx_valid_reg && host_held_reg;
   // Permission gates every start
   assign go_flow = rts_s && (need_xoff || need_xon);
   assign go_echo = rts_s && !paused_reg && echo_pend_reg && !go_flow;
   assign go_data = rts_s && !paused_reg && buf_out_valid && !echo_pend_reg && !go_flow;
   assign buf_out_ready = (tx_state_reg == S_IDLE) && go_data;
   // Host control characters are consumed only under software flow
   assign is_stop  = sw_en && (rx_sh_reg == stop_reg);
   assign is_start = sw_en && (rx_sh_reg == start_reg);
   assign rx_keep  = rx_done_reg && !is_stop && !is_start;
   assign rx_read  = bus_rd && (bus_addr == `HSFC_A_RXDATA);
   assign bdiv     = baud_div(ctrl_reg[`HSFC_F_BAUD_HI:`HSFC_F_BAUD_LO]);

   // ----------------------------------------------------------------
   // Register port
   // ----------------------------------------------------------------
   // Configuration writes; soft reset restores defaults but keeps the external reset enable bit
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_reg  <= `HSFC_CTRL_RST;
         xon_reg   <= `HSFC_XON_RST;
         xoff_reg  <= `HSFC_XOFF_RST;
         start_reg <= `HSFC_START_RST;
         stop_reg  <= `HSFC_STOP_RST;
      end
      else if (soft_reset)
      begin
         ctrl_reg  <= `HSFC_CTRL_RST | (ctrl_reg & 8'h80);
         xon_reg   <= `HSFC_XON_RST;
         xoff_reg  <= `HSFC_XOFF_RST;
         start_reg <= `HSFC_START_RST;
         stop_reg  <= `HSFC_STOP_RST;
      end
      else if (bus_wr)
      begin
         case (bus_addr)
            `HSFC_A_CTRL  : ctrl_reg  <= bus_wdata;
            `HSFC_A_XON   : xon_reg   <= bus_wdata;
            `HSFC_A_XOFF  : xoff_reg  <= bus_wdata;
            `HSFC_A_START : start_reg <= bus_wdata;
            `HSFC_A_STOP  : stop_reg  <= bus_wdata;
            default       : ;
         endcase
      end
   end

   // Read data stands one cycle after the strobe
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         bus_rdata <= 8'h00;
      else if (!bus_rd)
         bus_rdata <= 8'h00;
      else
      begin
         case (bus_addr)
            `HSFC_A_CTRL   : bus_rdata <= ctrl_reg;
            `HSFC_A_XON    : bus_rdata <= xon_reg;
            `HSFC_A_XOFF   : bus_rdata <= xoff_reg;
            `HSFC_A_START  : bus_rdata <= start_reg;
            `HSFC_A_STOP   : bus_rdata <= stop_reg;
            `HSFC_A_RXDATA : bus_rdata <= rx_hold_reg;
            `HSFC_A_STATUS : bus_rdata <= {1'b0, (tx_state_reg != S_IDLE), host_dcd, host_cts,
                                           rts_s, paused_reg, buf_in_ready, rx_valid_reg};
            default        : bus_rdata <= 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Baud tick at 16x the bit rate
   // ----------------------------------------------------------------
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bcnt_reg <= 13'h0000;
         tick_reg <= 1'b0;
      end
      else if (soft_reset || bcnt_reg >= bdiv - 13'h0001)
      begin
         bcnt_reg <= 13'h0000;
         tick_reg <= !soft_reset;
      end
      else
      begin
         bcnt_reg <= bcnt_reg + 13'h0001;
         tick_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Transmitter toward the host
   // ----------------------------------------------------------------
   // Chooses flow character, echo or buffered data; 8N1 framing
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_state_reg  <= S_IDLE;
         tx_sh_reg     <= 8'h00;
         tx_bit_reg    <= 3'h0;
         tx_ph_reg     <= 4'h0;
         host_rxd      <= 1'b1;
         host_held_reg <= 1'b0;
      end
      else if (soft_reset)
      begin
         tx_state_reg  <= S_IDLE;
         host_rxd      <= 1'b1;
         host_held_reg <= 1'b0;
      end
      else
      begin
         if (!sw_en)
            host_held_reg <= 1'b0;
         case (tx_state_reg)
            S_IDLE :
            begin
               host_rxd  <= 1'b1;
               tx_ph_reg <= 4'h0;
               if (go_flow)
               begin
                  tx_sh_reg     <= need_xoff ? xoff_reg : xon_reg;
                  host_held_reg <= need_xoff;
                  tx_state_reg  <= S_START;
               end
               else if (go_echo)
               begin
                  tx_sh_reg    <= echo_reg;
                  tx_state_reg <= S_START;
               end
               else if (go_data)
               begin
                  tx_sh_reg    <= buf_out_data;
                  tx_state_reg <= S_START;
               end
            end
            S_START :
            begin
               host_rxd <= 1'b0;
               if (tick_reg)
               begin
                  tx_ph_reg <= tx_ph_reg + 4'h1;
                  if (tx_ph_reg == 4'hf)
                  begin
                     tx_bit_reg   <= 3'h0;
                     tx_state_reg <= S_DATA;
                  end
               end
            end
            S_DATA :
            begin
               host_rxd <= tx_sh_reg[tx_bit_reg];
               if (tick_reg)
               begin
                  tx_ph_reg <= tx_ph_reg + 4'h1;
                  if (tx_ph_reg == 4'hf)
                  begin
                     tx_bit_reg <= tx_bit_reg + 3'h1;
                     if (tx_bit_reg == 3'h7)
                        tx_state_reg <= S_STOP;
                  end
               end
            end
            default :
            begin
               // One stop bit; permission is checked again only in idle
               host_rxd <= 1'b1;
               if (tick_reg)
               begin
                  tx_ph_reg <= tx_ph_reg + 4'h1;
                  if (tx_ph_reg == 4'hf)
                     tx_state_reg <= S_IDLE;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Receiver from the host
   // ----------------------------------------------------------------
   // Mid-bit sampling; a bad stop bit drops the byte
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_state_reg <= S_IDLE;
         rx_sh_reg    <= 8'h00;
         rx_bit_reg   <= 3'h0;
         rx_ph_reg    <= 4'h0;
         rx_done_reg  <= 1'b0;
      end
      else if (soft_reset)
      begin
         rx_state_reg <= S_IDLE;
         rx_done_reg  <= 1'b0;
      end
      else
      begin
         rx_done_reg <= 1'b0;
         case (rx_state_reg)
            S_IDLE :
            begin
               rx_ph_reg <= 4'h0;
               if (!rxd_s)
                  rx_state_reg <= S_START;
            end
            S_START :
               if (tick_reg)
               begin
                  rx_ph_reg <= rx_ph_reg + 4'h1;
                  if (rx_ph_reg == 4'h7)
                  begin
                     rx_ph_reg    <= 4'h0;
                     rx_bit_reg   <= 3'h0;
                     rx_state_reg <= rxd_s ? S_IDLE : S_DATA;
                  end
               end
            S_DATA :
               if (tick_reg)
               begin
                  rx_ph_reg <= rx_ph_reg + 4'h1;
                  if (rx_ph_reg == 4'hf)
                  begin
                     rx_sh_reg  <= {rxd_s, rx_sh_reg[7:1]};
                     rx_bit_reg <= rx_bit_reg + 3'h1;
                     if (rx_bit_reg == 3'h7)
                        rx_state_reg <= S_STOP;
                  end
               end
            default :
               if (tick_reg)
               begin
                  rx_ph_reg <= rx_ph_reg + 4'h1;
                  if (rx_ph_reg == 4'hf)
                  begin
                     rx_done_reg  <= rxd_s;
                     rx_state_reg <= S_IDLE;
                  end
               end
         endcase
      end
   end

   // Holding byte, echo and pause; a new byte beats a read
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_hold_reg   <= 8'h00;
         rx_valid_reg  <= 1'b0;
         echo_reg      <= 8'h00;
         echo_pend_reg <= 1'b0;
         paused_reg    <= 1'b0;
      end
      else if (soft_reset)
      begin
         rx_valid_reg  <= 1'b0;
         echo_pend_reg <= 1'b0;
         paused_reg    <= 1'b0;
      end
      else
      begin
         if (rx_keep)
         begin
            rx_hold_reg  <= rx_sh_reg;
            rx_valid_reg <= 1'b1;
         end
         else if (rx_read)
            rx_valid_reg <= 1'b0;
         if (rx_keep && ctrl_reg[`HSFC_F_ECHO])
         begin
            echo_reg      <= rx_sh_reg;
            echo_pend_reg <= 1'b1;
         end
         else if (tx_state_reg == S_IDLE && go_echo)
            echo_pend_reg <= 1'b0;
         if (!sw_en)
            paused_reg <= 1'b0;
         else if (rx_done_reg && is_stop)
            paused_reg <= 1'b1;
         else if (rx_done_reg && is_start)
            paused_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Modem lines, soft reset and mode outputs
   // ----------------------------------------------------------------
   // host_dtr is deliberately left unread
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         host_cts              <= 1'b0;
         host_dsr              <= 1'b0;
         host_dcd              <= 1'b0;
         tx_space              <= 1'b0;
         soft_reset            <= 1'b0;
         ext_prev_reg          <= 1'b1;
         extended_host_framing <= 1'b0;
         polled_active         <= 1'b0;
      end
      else
      begin
         host_cts              <= !rx_valid_reg && !rx_keep;
         host_dsr              <= 1'b1;
         host_dcd              <= stream_connected;
         tx_space              <= buf_in_ready;
         ext_prev_reg          <= ext_s;
         soft_reset            <= ctrl_reg[`HSFC_F_EXTRST] && ext_prev_reg && !ext_s;
         extended_host_framing <= ctrl_reg[`HSFC_F_XFRAME];
         polled_active         <= ctrl_reg[`HSFC_F_XFRAME] && ctrl_reg[`HSFC_F_POLLED];
      end
   end
endmodule

// file: rtl/hsfc_regs.vh
// Offsets, fields, reset values and timing counts of the host
// serial port. Definitions only.
`ifndef HSFC_REGS_VH
`define HSFC_REGS_VH
// ----------------------------------------------------------------
// Register offsets on the plain register port
// ----------------------------------------------------------------
`define HSFC_A_CTRL    3'h0
`define HSFC_A_XON     3'h1
`define HSFC_A_XOFF    3'h2
`define HSFC_A_START   3'h3
`define HSFC_A_STOP    3'h4
`define HSFC_A_TXDATA  3'h5
`define HSFC_A_RXDATA  3'h6
`define HSFC_A_STATUS  3'h7
// ----------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------
`define HSFC_F_BAUD_HI 2
`define HSFC_F_BAUD_LO 0
`define HSFC_F_ECHO    3
`define HSFC_F_XFLOW   4
`define HSFC_F_XFRAME  5
`define HSFC_F_POLLED  6
`define HSFC_F_EXTRST  7
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define HSFC_CTRL_RST  8'h1a
`define HSFC_XON_RST   8'h11
`define HSFC_XOFF_RST  8'h13
`define HSFC_START_RST 8'h11
`define HSFC_STOP_RST  8'h13
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define HSFC_CLK_HZ    20000000
`define HSFC_BAUD_MIN  300
`define HSFC_OVS       16
`endif

// file: rtl/hsfc_sync3.v
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes inputs arrive from outside the ref_clk domain.
`timescale 1ns/1ps
module hsfc_sync3
#(
   parameter       W       = 3,
   parameter [2:0] RST_VAL = 3'h7
)
(
   input  wire         ref_clk,
   input  wire         rst_n,
   input  wire [W-1:0] pin_in,
   output reg  [W-1:0] pin_out
);
   reg [W-1:0] s1_reg;
   reg [W-1:0] s2_reg;
   reg [W-1:0] s3_reg;

   // Chain of three flops; a change counts once stages two and three agree
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_reg  <= RST_VAL[W-1:0];
         s2_reg  <= RST_VAL[W-1:0];
         s3_reg  <= RST_VAL[W-1:0];
         pin_out <= RST_VAL[W-1:0];
      end
      else
      begin
         s1_reg <= pin_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg)
            pin_out <= s3_reg;
      end
   end
endmodule

// file: rtl/hsfc_buf2.v
// Two-entry buffer with valid and ready on both sides.
// Assumes a single clock; clr empties it synchronously.
`timescale 1ns/1ps
module hsfc_buf2
(
   input  wire       ref_clk,
   input  wire       rst_n,
   input  wire       clr,
   input  wire       in_valid,
   output wire       in_ready,
   input  wire [7:0] in_data,
   output wire       out_valid,
   input  wire       out_ready,
   output wire [7:0] out_data
);
   reg  [7:0] d0_reg;
   reg  [7:0] d1_reg;
   reg  [1:0] cnt_reg;
   wire       push;
   wire       pop;
   wire [1:0] slot;

   // Handshake terms
   assign in_ready  = (cnt_reg != 2'h2);
   assign out_valid = (cnt_reg != 2'h0);
   assign out_data  = d0_reg;
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   assign slot      = cnt_reg - {1'b0, pop};

   // Storage and occupancy
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         d0_reg  <= 8'h00;
         d1_reg  <= 8'h00;
         cnt_reg <= 2'h0;
      end
      else if (clr)
         cnt_reg <= 2'h0;
      else
      begin
         if (push && slot == 2'h0)
            d0_reg <= in_data;
         else if (pop)
            d0_reg <= d1_reg;
         if (push && slot == 2'h1)
            d1_reg <= in_data;
         cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule

// file: testbench/hsfc_top_sva.sv
// Checker for the host serial port, watching the top module's pins.
// Assumes the bench only drops host_rts while running at 19200 baud.
`timescale 1ns/1ps
module hsfc_top_sva
(
   input wire       ref_clk,
   input wire       rst_n,
   input wire       bus_rd,
   input wire [7:0] bus_rdata,
   input wire       host_txd,
   input wire       host_rxd,
   input wire       host_rts,
   input wire       host_cts,
   input wire       host_dsr,
   input wire       host_dcd,
   input wire       external_reset_input_n,
   input wire       stream_connected,
   input wire       soft_reset,
   input wire       extended_host_framing,
   input wire       polled_active
);
   reg [8:0] rts_lo_cnt;
   reg [11:0] txd_hi_cnt;
   // Saturating runs of withheld permission and of idle host data
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rts_lo_cnt <= 9'h000;
         txd_hi_cnt <= 12'h000;
      end
      else
      begin
         rts_lo_cnt <= host_rts ? 9'h000 : rts_lo_cnt + {8'h00, ~&rts_lo_cnt};
         txd_hi_cnt <= !host_txd ? 12'h000 : txd_hi_cnt + {11'h000, ~&txd_hi_cnt};
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   dsr_while_on_a : assert property ($past(rst_n) |-> host_dsr)
      else $error("dsr low while running");
   dcd_follows_a : assert property ($past(rst_n) |-> host_dcd == $past(stream_connected))
      else $error("dcd not following stream");
   polled_needs_frame_a : assert property (polled_active |-> extended_host_framing)
      else $error("polled without extended framing");
   soft_pulse_a : assert property (soft_reset |=> !soft_reset)
      else $error("soft reset pulse too long");
   soft_cause_a : assert property (soft_reset |-> !$past(external_reset_input_n, 3)
      || !$past(external_reset_input_n, 4) || !$past(external_reset_input_n, 5))
      else $error("soft reset without low input");
   rxd_idle_a : assert property (rts_lo_cnt > 9'h190 |-> host_rxd)
      else $error("data sent without permission");
   cts_drop_a : assert property ($fell(host_cts) |-> txd_hi_cnt < 12'h900)
      else $error("cts dropped without a character");
   rdata_idle_a : assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
      else $error("read data outside read slot");
   cover property (soft_reset);
   cover property ($fell(host_cts));
   cover property (rts_lo_cnt > 9'h190);
endmodule
bind hsfc_top hsfc_top_sva u_sva (.*);

// file: testbench/hsfc_host_model.sv
// Host terminal model: 8N1 sender, receiver and permission line.
// Assumes the bench sets bit_cyc to the device bit time in cycles.
`timescale 1ns/1ps
module hsfc_host_model
(
   input  wire ref_clk,
   input  wire host_rxd,
   input  wire host_cts,
   output reg  host_txd,
   output reg  host_rts
);
   integer   bit_cyc;
   integer   i;
   reg [7:0] c;
   reg [7:0] rxq [$];
   // Idle line high, permission granted
   initial
   begin
      bit_cyc  = 256;
      host_txd = 1'b1;
      host_rts = 1'b1;
   end
   // Send one character LSB first, held off while cts is low
   task send(input [7:0] d);
      integer   k;
      reg [9:0] fr;
      begin
         fr = {1'b1, d, 1'b0};
         for (k = 0; k < 9000 && !host_cts; k = k + 1)
            @(posedge ref_clk);
         for (k = 0; k < 10; k = k + 1)
         begin
            host_txd <= fr[k];
            repeat (bit_cyc) @(posedge ref_clk);
         end
      end
   endtask
   // Collect device characters; bad stop bits drop them
   always
   begin
      @(negedge host_rxd);
      repeat (bit_cyc / 2) @(posedge ref_clk);
      for (i = 0; i < 8; i = i + 1)
      begin
         repeat (bit_cyc) @(posedge ref_clk);
         c[i] = host_rxd;
      end
      repeat (bit_cyc) @(posedge ref_clk);
      if (host_rxd === 1'b1)
         rxq.push_back(c);
   end
endmodule

// file: testbench/host_serial_flow_control_tb.sv
// Bench for the host serial port: expected bytes queued and matched.
// Assumes CLK_HZ 307200, so one bit is 16 cycles at 19200 baud.
`timescale 1ns/1ps
module host_serial_flow_control_tb;
   reg        ref_clk;
   reg        rst_n;
   reg  [2:0] bus_addr;
   reg  [7:0] bus_wdata;
   reg        bus_wr;
   reg        bus_rd;
   reg        host_dtr;
   reg        external_reset_input_n;
   reg        stream_connected;
   wire [7:0] bus_rdata;
   wire       host_txd, host_rxd, host_rts, host_cts, host_dsr, host_dcd;
   wire       tx_space, soft_reset, extended_host_framing, polled_active;
   integer    n_errors, checks_done, n, e, sr_cnt;
   reg  [7:0] b;
   reg  [7:0] exp_q [$];
   hsfc_top #(.CLK_HZ(307200)) dut (.ref_clk, .rst_n, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
      .bus_rdata, .host_txd, .host_rxd, .host_rts, .host_cts, .host_dsr, .host_dcd, .host_dtr,
      .external_reset_input_n, .stream_connected, .tx_space, .soft_reset, .extended_host_framing,
      .polled_active);
   hsfc_host_model host (.ref_clk, .host_rxd, .host_cts, .host_txd, .host_rts);
   // Clock and soft reset pulse count
   always #25 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
      host_dtr <= ^$urandom;
   always @(posedge ref_clk)
      if (soft_reset === 1'b1)
         sr_cnt = sr_cnt + 1;
   task chk(input [7:0] got, input [7:0] exp);
      begin
         checks_done = checks_done + 1;
         if (got !== exp)
         begin
            n_errors = n_errors + 1;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task end_of_test;
      begin
         $display("checks %0d errors %0d", checks_done, n_errors);
         if (n_errors == 0 && checks_done > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   task wr(input [2:0] a, input [7:0] d);
      begin
         bus_addr <= a;
         bus_wdata <= d;
         bus_wr <= 1'b1;
         @(posedge ref_clk);
         bus_wr <= 1'b0;
         @(posedge ref_clk);
      end
   endtask
   task rd(input [2:0] a, input [7:0] x);
      begin
         bus_addr <= a;
         bus_rd <= 1'b1;
         @(posedge ref_clk);
         bus_rd <= 1'b0;
         #1 chk(bus_rdata, x);
         @(posedge ref_clk);
      end
   endtask
   // Wait for the expected bytes, compare in order
   task match;
      integer t;
      begin
         for (t = 0; t < 30000 && host.rxq.size() < exp_q.size(); t = t + 1)
            @(posedge ref_clk);
         repeat (300) @(posedge ref_clk);
         if (t == 30000)
         begin
            n_errors = n_errors + 1;
            end_of_test;
         end
         while (exp_q.size() > 0)
            chk(host.rxq.pop_front(), exp_q.pop_front());
         chk(8'(host.rxq.size()), 8'h00);
      end
   endtask
   // ----
   // Main sequence
   // ----
   initial
   begin
      ref_clk = 1'b0;
      rst_n = 1'b0;
      bus_addr = 3'h0;
      bus_wdata = 8'h00;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      external_reset_input_n = 1'b1;
      stream_connected = 1'b0;
      n_errors = 0;
      checks_done = 0;
      sr_cnt = 0;
      void'($urandom(32'hb5351562));
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rd(3'h0, 8'h1a);
      rd(3'h1, 8'h11);
      rd(3'h2, 8'h13);
      rd(3'h3, 8'h11);
      rd(3'h4, 8'h13);
      rd(3'h5, 8'h00);
      chk({7'h00, host_dsr}, 8'h01);
      $display("test reset done");
      b = 8'h20 | 8'($urandom);
      host.send(b);
      exp_q = '{8'h13, b};
      match;
      chk({7'h00, host_cts}, 8'h00);
      rd(3'h6, b);
      exp_q.push_back(8'h11);
      match;
      chk({7'h00, host_cts}, 8'h01);
      $display("test echo done");
      wr(3'h1, 8'h00);
      wr(3'h0, 8'h1e);
      host.bit_cyc = 16;
      host.send(8'h13);
      exp_q.push_back(8'h13);
      match;
      rd(3'h6, 8'h13);
      $display("test no flow done");
      wr(3'h1, 8'h11);
      host.send(8'h13);
      rd(3'h7, 8'h1e);
      b = 8'h20 | 8'($urandom);
      wr(3'h5, b);
      repeat (400) @(posedge ref_clk);
      chk(8'(host.rxq.size()), 8'h00);
      host.send(8'h11);
      exp_q.push_back(b);
      match;
      $display("test host stop done");
      host.host_rts <= 1'b0;
      repeat (8) @(posedge ref_clk);
      #1 n = 0;
      while (tx_space === 1'b1 && n < 8)
      begin
         b = 8'h20 | 8'($urandom);
         wr(3'h5, b);
         exp_q.push_back(b);
         n = n + 1;
         #1;
      end
      wr(3'h5, 8'h5a);
      #1 chk({7'h00, tx_space}, 8'h00);
      repeat (600) @(posedge ref_clk);
      chk(8'(host.rxq.size()), 8'h00);
      host.host_rts <= 1'b1;
      match;
      $display("test permission done");
      for (n = 0; n < 6; n = n + 1)
      begin
         stream_connected <= ^$urandom;
         repeat (3) @(posedge ref_clk);
         chk({7'h00, host_dcd}, {7'h00, stream_connected});
      end
      wr(3'h0, 8'h5e);
      #1 chk({7'h00, polled_active}, 8'h00);
      wr(3'h0, 8'h7e);
      #1 chk({extended_host_framing, polled_active}, 8'h03);
      $display("test lines done");
      for (e = 0; e < 2; e = e + 1)
      begin
         wr(3'h0, {e[0], 7'h1e});
         wr(3'h1, 8'h55);
         external_reset_input_n <= 1'b0;
         repeat (20) @(posedge ref_clk);
         external_reset_input_n <= 1'b1;
         repeat (10) @(posedge ref_clk);
         chk(8'(sr_cnt), 8'(e));
         rd(3'h1, e ? 8'h11 : 8'h55);
      end
      rd(3'h0, 8'h9a);
      $display("test soft reset done");
      end_of_test;
   end
endmodule
